// *** logic/wdt_unit.sv ***
// Watchdog timer with APB register access, unlock window and interrupt.
`timescale 1ns/100ps
`default_nettype none

module wdt_unit #(
    parameter int unsigned BASE_OSC_CYC = wdt_pkg::BASE_OSC_CYC,  // Period for select 000.
    parameter int unsigned CNT_W        = wdt_pkg::CNT_W          // Period counter width.
) (
    input  wire logic        pclk,                   // System clock, 10 MHz.
    input  wire logic        presetn,                // Asynchronous reset, active low.
    input  wire logic        psel,                   // APB select.
    input  wire logic        penable,                // APB access phase.
    input  wire logic        pwrite,                 // APB direction, high for write.
    input  wire logic [7:0]  paddr,                  // APB byte address.
    input  wire logic [31:0] pwdata,                 // APB write data.
    output var  logic [31:0] prdata,                 // APB read data.
    output var  logic        pready,                 // APB ready.
    output var  logic        pslverr,                // APB error for unmapped address.
    input  wire logic        osc_clk_in,             // Watchdog oscillator pin.
    input  wire logic        kick_instruction,       // Restart pulse from the processor core.
    output var  logic        wdt_reset,              // One-cycle system reset request.
    output var  logic        irq                     // Level interrupt.
);

    ////////////////////////////////////////////////////////////////////////////////
    // Elaboration checks.

    // The base period must be a power of two of at least two, and the counter
    // must hold the longest period less one.
    if ((BASE_OSC_CYC < 2) || ((BASE_OSC_CYC & (BASE_OSC_CYC - 1)) != 0)) begin : g_bad_base
        $error("wdt_unit: base period must be a power of two");
    end
    if (CNT_W < $clog2(BASE_OSC_CYC) + 7 || CNT_W > 31) begin : g_bad_cnt
        $error("wdt_unit: counter width does not fit the longest period");
    end
    // The synchroniser needs three pclk samples per oscillator half wave.
    if (wdt_pkg::PCLK_PER_OSC / 2 < wdt_pkg::SYNC_MIN_HALF) begin : g_bad_rate
        $error("wdt_unit: system clock too slow for the oscillator");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    // Every register of the block, apart from those of the oscillator synchroniser, sits in this one struct.
    typedef struct packed {
        logic                             unlock;    // Change-unlock bit.
        logic [2:0]                       ucnt;      // Cycles left in the unlock window.
        logic                             dog_on;    // Watchdog enable bit.
        logic [wdt_pkg::SEL_W-1:0]        sel;       // Period select.
        logic [wdt_pkg::LEVEL_W-1:0]      level;     // Safety level.
        logic [wdt_pkg::STAT_W-1:0]       status;    // Sticky event flags.
        logic [wdt_pkg::STAT_W-1:0]       mask;      // Interrupt mask.
        logic [CNT_W-1:0]                 cnt;       // Oscillator cycles in this period.
        logic [31:0]                      prdata;    // Registered read data.
        logic                             pready;    // Registered ready.
        logic                             pslverr;   // Registered error.
        logic                             wdt_reset; // Registered reset request.
        logic                             irq;       // Registered interrupt.
    } wdt_state_t;

    wdt_state_t st;                                  // Present state.
    wdt_state_t next_st;                             // Next state.

    logic osc_tick;                                  // One pulse per oscillator rise.
    logic wr_commit;                                 // A write takes effect this edge.

    ////////////////////////////////////////////////////////////////////////////////
    // Functions.

    // True for every offset that holds a register.
    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = (addr == wdt_pkg::OFF_CTRL)   ||
                    (addr == wdt_pkg::OFF_STATUS) ||
                    (addr == wdt_pkg::OFF_MASK)   ||
                    (addr == wdt_pkg::OFF_LEVEL)  ||
                    (addr == wdt_pkg::OFF_COUNT);
    endfunction

    // Control register as software sees it.
    function automatic logic [31:0] ctrl_word(input wdt_state_t s);
        ctrl_word = {24'h000000, wdt_pkg::RESV_VALUE,
                     s.unlock, s.dog_on, s.sel};
    endfunction

    // Read multiplexer; unmapped offsets read zero.
    function automatic logic [31:0] read_word(input logic [7:0] addr, input wdt_state_t s);
        case (addr)
            wdt_pkg::OFF_CTRL:   read_word = ctrl_word(s);
            wdt_pkg::OFF_STATUS: read_word = {30'h00000000, s.status};
            wdt_pkg::OFF_MASK:   read_word = {30'h00000000, s.mask};
            wdt_pkg::OFF_LEVEL:  read_word = {30'h00000000, s.level};
            wdt_pkg::OFF_COUNT:  read_word = {{(32 - CNT_W){1'b0}}, s.cnt};
            default:             read_word = 32'h00000000;
        endcase
    endfunction

    // Last count of a period: the base doubled once per select step, less one.
    function automatic logic [31:0] period_last(input logic [wdt_pkg::SEL_W-1:0] code);
        period_last = (32'(BASE_OSC_CYC) << code) - 32'h00000001;
    endfunction

    // Safety levels 1 and 2 lock the period select.
    function automatic logic sel_locked(input logic [wdt_pkg::LEVEL_W-1:0] lvl);
        sel_locked = (lvl == wdt_pkg::LEVEL_ONE) || (lvl == wdt_pkg::LEVEL_TWO);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Oscillator input.

    // The oscillator is not related to pclk, so it is synchronised and each of
    // its rising edges becomes one pclk pulse. Counting stays in the pclk domain,
    // which keeps the register file free of any crossing.
    wdt_osc_sync u_osc_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (osc_clk_in),
        .tick     (osc_tick)
    );

    // A write is committed at the edge where the master sees pready high.
    assign wr_commit = psel & penable & pwrite & st.pready;

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    always_comb begin
        next_st           = st;
        next_st.pready    = 1'b0;
        next_st.pslverr   = 1'b0;
        next_st.wdt_reset = 1'b0;

        // Unlock window: the bit drops at the fourth edge after the write
        // that set it, unless a later write renews it.
        if (st.ucnt != 3'h0) begin
            next_st.ucnt = st.ucnt - 3'h1;
            if (st.ucnt == 3'h1) begin
                next_st.unlock = 1'b0;
            end
        end

        // APB: ready one cycle into the access phase; read data and error
        // are captured with it so they are stable while ready is high.
        if (psel && penable && !st.pready) begin
            next_st.pready  = 1'b1;
            next_st.pslverr = ~is_mapped(paddr);
            next_st.prdata  = pwrite ? 32'h00000000 : read_word(paddr, st);
        end

        // Register writes. Unmapped offsets are ignored apart from the error.
        if (wr_commit) begin
            case (paddr)
                wdt_pkg::OFF_CTRL: begin
                    // Enable: setting always works; clearing needs the
                    // unlock bit as it stood before this write.
                    if (pwdata[wdt_pkg::BIT_ON]) begin
                        next_st.dog_on = 1'b1;
                    end else if (st.unlock) begin
                        next_st.dog_on = 1'b0;
                    end else if (st.dog_on) begin
                        next_st.status[wdt_pkg::STAT_REFUSED] = 1'b1;
                    end
                    // Period select: locked at safety levels 1 and 2.
                    if (!sel_locked(st.level) || st.unlock) begin
                        next_st.sel = pwdata[wdt_pkg::SEL_LSB +: wdt_pkg::SEL_W];
                    end else if (pwdata[wdt_pkg::SEL_LSB +: wdt_pkg::SEL_W] != st.sel) begin
                        next_st.status[wdt_pkg::STAT_REFUSED] = 1'b1;
                    end
                    // Writing the unlock bit opens a fresh four-cycle window.
                    if (pwdata[wdt_pkg::BIT_UNLOCK]) begin
                        next_st.unlock = 1'b1;
                        next_st.ucnt   = 3'(wdt_pkg::UNLOCK_CYC);
                    end
                end
                wdt_pkg::OFF_STATUS: begin
                    // Write one to clear; events below are applied after
                    // this, so an event in the same cycle wins.
                    next_st.status = st.status & ~pwdata[wdt_pkg::STAT_W-1:0];
                    if (st.status[wdt_pkg::STAT_REFUSED]) begin
                        next_st.status[wdt_pkg::STAT_REFUSED] =
                            ~pwdata[wdt_pkg::STAT_REFUSED];
                    end
                end
                wdt_pkg::OFF_MASK: begin
                    next_st.mask = pwdata[wdt_pkg::STAT_W-1:0];
                end
                wdt_pkg::OFF_LEVEL: begin
                    next_st.level = pwdata[wdt_pkg::LEVEL_W-1:0];
                end
                default: begin
                    // Read-only or unmapped: nothing changes.
                end
            endcase
        end

        // Period counter. A kick has priority over an oscillator tick in the
        // same cycle. The counter is frozen, not cleared, while disabled, so
        // software must kick before enabling to get a full first period.
        if (kick_instruction) begin
            next_st.cnt = '0;
        end else if (st.dog_on && osc_tick) begin
            if (32'(st.cnt) == period_last(st.sel)) begin
                next_st.cnt       = '0;
                next_st.wdt_reset = 1'b1;
                next_st.status[wdt_pkg::STAT_TIMEOUT] = 1'b1;
            end else begin
                next_st.cnt = st.cnt + CNT_W'(1);
            end
        end

        // Interrupt follows the flags and mask that are about to be stored.
        next_st.irq = |(next_st.status & next_st.mask);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register.

    // Reset loads constants only; the watchdog starts disabled.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st        <= '0;
            st.dog_on <= wdt_pkg::ON_RESET;
            st.sel    <= wdt_pkg::SEL_RESET;
            st.level  <= wdt_pkg::LEVEL_RESET;
            st.status <= wdt_pkg::STAT_RESET;
            st.mask   <= wdt_pkg::MASK_RESET;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state register.

    assign prdata    = st.prdata;
    assign pready    = st.pready;
    assign pslverr   = st.pslverr;
    assign wdt_reset = st.wdt_reset;
    assign irq       = st.irq;

endmodule // wdt_unit

`default_nettype wire

// *** logic/wdt_pkg.sv ***
// Package with register map, field layout, reset values and timing figures of the watchdog.
package wdt_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus geometry.
    localparam int ADDR_W = 8;                       // APB address width in bits.
    localparam int DATA_W = 32;                      // APB data width in bits.

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets, one aligned word each.
    localparam logic [7:0] OFF_CTRL   = 8'h00;       // Watchdog control register.
    localparam logic [7:0] OFF_STATUS = 8'h04;       // Sticky event flags, write one to clear.
    localparam logic [7:0] OFF_MASK   = 8'h08;       // Interrupt mask, same layout as status.
    localparam logic [7:0] OFF_LEVEL  = 8'h0C;       // Safety level of the device.
    localparam logic [7:0] OFF_COUNT  = 8'h10;       // Read-only view of the period counter.

    ////////////////////////////////////////////////////////////////////////////////
    // Control register fields.
    localparam int CTRL_W     = 8;                   // Width of the control register.
    localparam int BIT_UNLOCK = 4;                   // Change-unlock bit.
    localparam int BIT_ON     = 3;                   // Watchdog enable bit.
    localparam int SEL_LSB    = 0;                   // Lowest bit of the period select.
    localparam int SEL_W      = 3;                   // Width of the period select.
    localparam logic [2:0] RESV_VALUE = 3'h0;        // Bits seven to five always read zero.
    localparam logic       ON_RESET   = 1'b0;        // Enable bit after reset.
    localparam logic [2:0] SEL_RESET  = 3'h0;        // Period select after reset.

    ////////////////////////////////////////////////////////////////////////////////
    // Status and mask fields.
    localparam int STAT_W       = 2;                 // Number of event flags.
    localparam int STAT_TIMEOUT = 0;                 // Period expired, reset was asserted.
    localparam int STAT_REFUSED = 1;                 // A locked change was refused.
    localparam logic [1:0] STAT_RESET = 2'h0;        // Status flags after reset.
    localparam logic [1:0] MASK_RESET = 2'h0;        // Mask after reset, all events masked.

    ////////////////////////////////////////////////////////////////////////////////
    // Safety level field.
    localparam int LEVEL_W = 2;                      // Width of the safety level field.
    localparam logic [1:0] LEVEL_RESET = 2'h0;       // Safety level after reset.
    localparam logic [1:0] LEVEL_ONE   = 2'h1;       // Safety level 1.
    localparam logic [1:0] LEVEL_TWO   = 2'h2;       // Safety level 2.

    ////////////////////////////////////////////////////////////////////////////////
    // Timing.
    localparam int UNLOCK_CYC     = 4;               // Clock cycles the unlock bit stays set.
    localparam int PCLK_PERIOD_NS = 100;             // System clock period, 10 MHz.
    localparam int OSC_PERIOD_NS  = 1000;            // Watchdog oscillator period, 1 MHz.
    localparam int PCLK_PER_OSC   = OSC_PERIOD_NS / PCLK_PERIOD_NS;
    localparam int SYNC_MIN_HALF  = 3;               // Least pclk cycles per oscillator half wave.
    localparam int BASE_OSC_CYC   = 16384;           // Oscillator cycles for period select 000.
    localparam int CNT_W          = 21;              // Counter width, holds the longest period.

endpackage

// *** logic/wdt_osc_sync.sv ***
// Synchroniser and rising edge detector for the watchdog oscillator pin.
`timescale 1ns/100ps
`default_nettype none

module wdt_osc_sync (
    input  wire logic pclk,                          // System clock.
    input  wire logic presetn,                       // Asynchronous reset, active low.
    input  wire logic async_in,                      // Raw oscillator pin.
    output var  logic tick                           // One-cycle pulse per oscillator rise.
);

    ////////////////////////////////////////////////////////////////////////////////
    // All state lives in one packed struct.
    typedef struct packed {
        logic s1;                                    // First stage, read only by s2.
        logic s2;                                    // Second stage.
        logic s3;                                    // Third stage.
        logic level;                                 // Accepted level of the pin.
        logic tick;                                  // Registered rise pulse.
    } wdt_sync_t;

    wdt_sync_t st;                                   // Present state.
    wdt_sync_t next_st;                              // Next state.

    ////////////////////////////////////////////////////////////////////////////////
    // A change is accepted only once stages two and three agree, which filters
    // a single metastable sample at the cost of one extra cycle of latency.
    always_comb begin
        next_st       = st;
        next_st.s1    = async_in;
        next_st.s2    = st.s1;
        next_st.s3    = st.s2;
        next_st.tick  = 1'b0;
        if (st.s2 == st.s3) begin
            next_st.level = st.s2;
            next_st.tick  = st.s2 & ~st.level;      // Rise of the accepted level.
        end
    end

    // Register the state; reset loads constants only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;

endmodule // wdt_osc_sync

`default_nettype wire

// *** sim/wdt_unit_monitor.sv ***
// Concurrent checks on the ports of the watchdog unit, bound to every instance.
`timescale 1ns/100ps
`default_nettype none

module wdt_unit_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        osc_clk_in,
    input wire logic        kick_instruction,
    input wire logic        wdt_reset,
    input wire logic        irq
);
    // One clock domain, so every check shares the system clock and sleeps in reset.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////
    // Bus handshake: one wait state, one-cycle answer, error reads as zero; no interrupt right after reset.
    a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing one cycle into the access phase");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer without ready or with data");
    a_irq_after_reset: assert property ($rose(presetn) |-> !irq)
        else $error("interrupt high right after reset");

    ////////////////////////////////////////////////////////////
    // Control register contents and the timeout path.
    a_resv_read_zero: assert property (
        pready && !pwrite && paddr == wdt_pkg::OFF_CTRL |-> prdata[31:5] == 27'h0)
        else $error("reserved control bits read as one");
    a_unlock_visible: assert property (
        (psel && penable && pready && pwrite && paddr == wdt_pkg::OFF_CTRL && pwdata[4])
        ##3 (pready && !pwrite && paddr == wdt_pkg::OFF_CTRL) |-> prdata[4])
        else $error("unlock bit gone within the four-cycle window");
    a_reset_pulse: assert property (wdt_reset |=> !wdt_reset)
        else $error("reset request longer than one cycle");
    // A kick zeroes the count, so no timeout can follow in the next cycles.
    a_kick_restart: assert property (kick_instruction |-> ##2 !wdt_reset [*8])
        else $error("timeout right after a kick");
    // Timeouts are paced by the oscillator; a rise must precede the request.
    a_reset_needs_osc: assert property (wdt_reset |-> $past(osc_clk_in, 3))
        else $error("timeout without an oscillator rise");
endmodule // wdt_unit_monitor

bind wdt_unit wdt_unit_monitor wdt_unit_monitor_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_clk_in(osc_clk_in), .kick_instruction(kick_instruction),
    .wdt_reset(wdt_reset), .irq(irq));

`default_nettype wire

// *** sim/wdt_unit_bench.sv ***
// Self-checking bench of the watchdog unit: registers, unlock window, timeouts, interrupt.
`timescale 1ns/100ps
`default_nettype none

module wdt_unit_bench;
    localparam int BASE = 16;                        // Short period keeps the run brief.
    logic        pclk, presetn, psel, penable, pwrite, osc_clk_in, kick_instruction, osc_run;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, wdt_reset, irq, er;
    int          n_fail, n_checks, rises, ph;

    wdt_unit #(.BASE_OSC_CYC(BASE), .CNT_W(21)) wdt_unit_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .osc_clk_in(osc_clk_in), .kick_instruction(kick_instruction),
        .wdt_reset(wdt_reset), .irq(irq));

    // System clock, 10 MHz.
    initial begin
        pclk = 1'h0;
        forever #50 pclk = ~pclk;
    end

    // Oscillator at 1 MHz, five system cycles per half wave; rises are counted.
    // It idles low when stopped so no tick is left in flight.
    always @(posedge pclk) begin
        ph <= (ph == 4) ? 0 : ph + 1;
        if (!osc_run) begin
            osc_clk_in <= 1'h0;
        end else if (ph == 4) begin
            osc_clk_in <= !osc_clk_in;
            rises <= rises + (osc_clk_in ? 0 : 1);
        end
    end

    ////////////////////////////////////////////////////////////
    // Shared tasks.
    task automatic stop_test;
        if (n_fail == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // One transfer; hold keeps psel up for a back-to-back transfer, else an idle edge passes.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic h);
        int n;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        for (n = 0; n < 8; n++) begin
            @(posedge pclk);
            if (pready === 1'h1) break;
        end
        if (n == 8) begin
            n_fail++;
            $display("wrong value at %0t ns: no pready", $time);
            stop_test();
        end
        rd = prdata;
        er = pslverr;
        penable <= 1'h0;
        if (!h) begin
            psel <= 1'h0;
            @(posedge pclk);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic h);
        apb(1'h1, a, d, h);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0, 1'h0);
        chk(rd, e);
    endtask

    task automatic kick;
        kick_instruction <= 1'h1;
        @(posedge pclk);
        kick_instruction <= 1'h0;
    endtask

    ////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_regs;
        rdchk(wdt_pkg::OFF_CTRL, 32'h0);
        rdchk(wdt_pkg::OFF_STATUS, 32'h0);
        rdchk(wdt_pkg::OFF_MASK, 32'h0);
        rdchk(wdt_pkg::OFF_LEVEL, 32'h0);
        wr(8'h14, 32'h1, 1'h0);
        chk({31'h0, er}, 32'h1);
        wr(wdt_pkg::OFF_CTRL, 32'hFF, 1'h1);
        rdchk(wdt_pkg::OFF_CTRL, 32'h1F);
        repeat (4) @(posedge pclk);
        rdchk(wdt_pkg::OFF_CTRL, 32'h0F);
    endtask

    // Locked clear, a clear one cycle too late, at the last edge, and back to back.
    task automatic t_disable;
        wr(wdt_pkg::OFF_CTRL, 32'h00, 1'h0);
        rdchk(wdt_pkg::OFF_CTRL, 32'h08);
        rdchk(wdt_pkg::OFF_STATUS, 32'h2);
        wr(wdt_pkg::OFF_CTRL, 32'h18, 1'h0);
        @(posedge pclk);
        wr(wdt_pkg::OFF_CTRL, 32'h00, 1'h0);
        rdchk(wdt_pkg::OFF_CTRL, 32'h08);
        wr(wdt_pkg::OFF_CTRL, 32'h18, 1'h0);
        wr(wdt_pkg::OFF_CTRL, 32'h00, 1'h0);
        rdchk(wdt_pkg::OFF_CTRL, 32'h00);
        wr(wdt_pkg::OFF_CTRL, 32'h08, 1'h0);
        wr(wdt_pkg::OFF_CTRL, 32'h18, 1'h1);
        wr(wdt_pkg::OFF_CTRL, 32'h00, 1'h0);
        rdchk(wdt_pkg::OFF_CTRL, 32'h00);
    endtask

    // At levels one and two the select moves only inside a window opened by an
    // earlier unlock write; the unlock is judged as it stood before each write.
    task automatic t_level;
        for (int lv = 1; lv <= 2; lv++) begin
            wr(wdt_pkg::OFF_LEVEL, 32'(lv), 1'h0);
            wr(wdt_pkg::OFF_CTRL, 32'(lv * 3), 1'h0);
            rdchk(wdt_pkg::OFF_CTRL, 32'((lv - 1) * 3));
            wr(wdt_pkg::OFF_CTRL, 32'h10 | 32'((lv - 1) * 3), 1'h1);
            wr(wdt_pkg::OFF_CTRL, 32'(lv * 3), 1'h1);
            rdchk(wdt_pkg::OFF_CTRL, 32'(lv * 3));
        end
        wr(wdt_pkg::OFF_LEVEL, 32'h0, 1'h0);
        wr(wdt_pkg::OFF_CTRL, 32'h05, 1'h0);
        rdchk(wdt_pkg::OFF_CTRL, 32'h05);
    endtask

    // Every select code: kick mid-period, then count rises to the timeout.
    task automatic t_timeout;
        int r0;
        int n;
        osc_run <= 1'h1;
        wr(wdt_pkg::OFF_STATUS, 32'h3, 1'h0);
        for (int s = 0; s < 8; s++) begin
            wr(wdt_pkg::OFF_MASK, 32'(s == 0), 1'h0);
            kick();
            r0 = rises;
            wr(wdt_pkg::OFF_CTRL, 32'h08 | 32'(s), 1'h0);
            for (n = 0; n < 200 && rises < r0 + 8; n++) @(posedge pclk);
            repeat (6) @(posedge pclk);
            kick();
            r0 = rises;
            // Read right at the edge: this sees the value that stood through the
            // cycle before it, so the next request still starts on an edge.
            for (n = 0; n < 30000; n++) begin
                @(posedge pclk);
                if (wdt_reset === 1'h1) break;
            end
            if (n == 30000) begin
                n_fail++;
                $display("wrong value at %0t ns: no timeout", $time);
                stop_test();
            end
            chk(32'(rises - r0), 32'(BASE << s));
            chk({31'h0, irq}, 32'(s == 0));
            if (s == 0) rdchk(wdt_pkg::OFF_STATUS, 32'h1);
            wr(wdt_pkg::OFF_STATUS, 32'h1, 1'h0);
            chk({31'h0, irq}, 32'h0);
            wr(wdt_pkg::OFF_CTRL, 32'h18, 1'h1);
            wr(wdt_pkg::OFF_CTRL, 32'h00, 1'h0);
        end
        osc_run <= 1'h0;
    endtask

    ////////////////////////////////////////////////////////////
    // Reset for 20 cycles, run the scenarios, report once.
    initial begin
        {psel, penable, pwrite, kick_instruction, osc_run, osc_clk_in} = 6'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        presetn = 1'h0;
        {n_fail, n_checks, rises, ph} = {4{32'h0}};
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        t_regs();
        t_disable();
        t_level();
        t_timeout();
        stop_test();
    end
endmodule // wdt_unit_bench

`default_nettype wire
